/* File: core/self_prog_params.svh */
`ifndef SELF_PROG_PARAMS_SVH
`define SELF_PROG_PARAMS_SVH

// Clocking of the flash port
`define SYS_CLK_HZ         40000000
`define SPI_CLK_HZ         20000000
`define SCK_HALF_RAW       (`SYS_CLK_HZ / (2 * `SPI_CLK_HZ))
`define SCK_HALF_CYCLES    ((`SCK_HALF_RAW) < 1 ? 1 : (`SCK_HALF_RAW))
`define SCK_DIV_LAST       2'((`SCK_HALF_CYCLES) - 1)
`define SCK_IDLE_LEVEL     1'b1

// Descriptor fields
`define DESC_CMD_MSB       6
`define DESC_CMD_LSB       0
`define DESC_OFF_MSB       15
`define DESC_OFF_LSB       7
`define DESC_IDX_MSB       14
`define DESC_IDX_LSB       7

// Service command codes
`define CMD_IMAGE_AUTH     7'h22
`define CMD_BITSTREAM_AUTH 7'h23
`define CMD_AUTO_UPDATE    7'h46
`define CMD_IN_APPLICATION 7'h42

// Status codes
`define STATUS_OK          8'h00
`define ERR_NOT_MASTER     8'h01
`define ERR_UNKNOWN_CMD    8'h02
`define ERR_AUTH_FAIL      8'h03

// Flash access
`define FLASH_READ_OP      8'h03
`define FLASH_ADDR_BYTES   3'h3
`define FLASH_DUMMY_TX     8'h00
`define UPDATE_IMAGE_ADDR  32'h00001000
`define IN_APPLICATION_ADDR 32'h00002000
`define DIR_BASE_ADDR      32'h00100000
`define DIR_STRIDE_SHIFT   16
// Image length is a plain default, kept short so a full run stays brief
`define IMAGE_BYTES        16'h0100

// Mailbox
`define MBOX_WORDS         512
`define MBOX_AW            9

`endif

/* File: core/self_prog_pkg.sv */
package self_prog_pkg;

	typedef enum logic [6:0] {
		ST_BOOT   = 7'b0000001,
		ST_IDLE   = 7'b0000010,
		ST_FETCH  = 7'b0000100,
		ST_CMD    = 7'b0001000,
		ST_DATA   = 7'b0010000,
		ST_FINISH = 7'b0100000,
		ST_REPORT = 7'b1000000
	} state_t;

	typedef enum logic [1:0] {
		JOB_PROGRAM = 2'h0,
		JOB_UPDATE  = 2'h1,
		JOB_AUTH    = 2'h2,
		JOB_IN_APPLICATION = 2'h3
	} job_t;

	typedef struct packed {
		logic [7:0] head;
		logic [7:0] tail;
		logic       out_valid;
		logic       in_ready;
	} buf_t;

	typedef struct packed {
		state_t                 state;
		job_t                   job;
		logic                   en_strap;
		logic                   role_strap;
		logic [31:0]            addr;
		logic [15:0]            count;
		logic [2:0]             hdr;
		logic [2:0]             bit_cnt;
		logic [7:0]             tx;
		logic [7:0]             rx;
		logic                   xfer;
		logic                   have_rx;
		logic [1:0]             div;
		logic                   sck;
		logic                   ss_n;
		logic                   sdo;
		logic                   spi_oe_n;
		logic [7:0]             chk;
		logic                   push;
		logic [7:0]             push_data;
		logic                   busy;
		logic                   desc_ready;
		logic                   status_valid;
		logic [7:0]             status_code;
		logic                   jtag_fail;
		logic                   block_ports;
		logic                   fabric_grant;
		logic                   restart;
		logic                   prog_done;
		logic                   auth_passed;
		logic [8:0]             mbox_ptr;
		logic [31:0]            mbox_rdata;
		logic [511:0][31:0]     mbox;
	} ctrl_t;

endpackage

/* File: core/two_entry_buffer.sv */
`timescale 1ns/1ps

module two_entry_buffer
	import self_prog_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	input  wire logic       in_valid,
	input  wire logic [7:0] in_data,
	output logic            in_ready,
	output logic            out_valid,
	output logic [7:0]      out_data,
	input  wire logic       out_ready
);

	buf_t s;
	buf_t n;
	logic push;
	logic pop;

	always_comb
	begin
		n = s;
		push = in_valid & s.in_ready;
		pop = s.out_valid & out_ready;
		unique case ({push, pop})
			2'b10:
			begin
				if (!s.out_valid)
				begin
					n.head = in_data;
					n.out_valid = 1'b1;
				end
				else
				begin
					n.tail = in_data;
					n.in_ready = 1'b0;
				end
			end
			2'b01:
			begin
				if (!s.in_ready)
				begin
					n.head = s.tail;
					n.in_ready = 1'b1;
				end
				else
					n.out_valid = 1'b0;
			end
			2'b11:
				n.head = in_data;
			default:
				n = s;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.in_ready <= 1'b1;
		end
		else
			s <= n;
	end

	assign in_ready = s.in_ready;
	assign out_valid = s.out_valid;
	assign out_data = s.head;

endmodule

/* File: core/self_program_services.sv */
`timescale 1ns/1ps
`include "self_prog_params.svh"

module self_program_services
	import self_prog_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        port_enable_strap,
	input  wire logic        port_role_strap,
	input  wire logic        suspend_mode,
	input  wire logic        auto_update_enable,
	input  wire logic        device_blank,
	input  wire logic        version_differs,
	input  wire logic        recovery_pending,
	input  wire logic        secure_nonvolatile_memory_interrupted,
	input  wire logic        image_authenticated,
	input  wire logic        jtag_load_active,
	input  wire logic        desc_valid,
	input  wire logic [15:0] desc,
	output logic             desc_ready,
	output logic             busy,
	output logic             status_valid,
	output logic [7:0]       status_code,
	input  wire logic        mbox_wr_en,
	input  wire logic [8:0]  mbox_addr,
	input  wire logic [31:0] mbox_wdata,
	output logic [31:0]      mbox_rdata,
	output logic             spi_sck_o,
	output logic             spi_sck_oe_n,
	output logic             spi_ss_n_o,
	output logic             spi_ss_oe_n,
	output logic             spi_sdo,
	output logic             spi_sdo_oe_n,
	input  wire logic        spi_sdi,
	output logic             fabric_spi_grant,
	output logic             port_block,
	output logic             jtag_fail,
	output logic             auth_passed,
	output logic             restart_request,
	output logic             prog_done,
	output logic             prog_valid,
	output logic [7:0]       prog_data,
	input  wire logic        prog_ready
);

	ctrl_t      s;
	ctrl_t      n;
	logic       allowed;
	logic       boot_ok;
	logic       byte_done;
	logic       buf_ready;
	logic [6:0] cmd;
	logic [8:0] offset;
	logic [7:0] index;

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic [7:0] addr_byte(input logic [31:0] a, input logic [2:0] idx);
		logic [31:0] t;
		t = a >> (8 * (`FLASH_ADDR_BYTES - idx));
		return t[7:0];
	endfunction

	function automatic ctrl_t start_byte(input ctrl_t c, input logic [7:0] b);
		ctrl_t r;
		r = c;
		r.tx = b;
		r.xfer = 1'b1;
		r.bit_cnt = 3'h0;
		r.div = 2'h0;
		return r;
	endfunction

	// Opens a flash read and claims the port until the job ends
	function automatic ctrl_t begin_job(input ctrl_t c, input job_t j, input logic [31:0] a);
		ctrl_t r;
		r = c;
		r.job = j;
		r.addr = a;
		r.hdr = 3'h0;
		r.count = `IMAGE_BYTES;
		r.chk = 8'h00;
		r.have_rx = 1'b0;
		r.state = ST_CMD;
		r.busy = 1'b1;
		r.desc_ready = 1'b0;
		r.fabric_grant = 1'b0;
		r.block_ports = 1'b1;
		r.ss_n = 1'b0;
		r.spi_oe_n = ~c.en_strap;
		return r;
	endfunction

	function automatic ctrl_t report(input ctrl_t c, input logic [7:0] code);
		ctrl_t r;
		r = c;
		r.status_code = code;
		r.state = ST_REPORT;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	assign allowed = s.en_strap & s.role_strap & ~suspend_mode;
	assign boot_ok = port_enable_strap & port_role_strap & ~suspend_mode;
	assign cmd = desc[`DESC_CMD_MSB:`DESC_CMD_LSB];
	assign offset = desc[`DESC_OFF_MSB:`DESC_OFF_LSB];
	assign index = desc[`DESC_IDX_MSB:`DESC_IDX_LSB];
	assign byte_done = s.xfer && s.div == `SCK_DIV_LAST && !s.sck && s.bit_cnt == 3'h7;

	always_comb
	begin
		n = s;
		n.push = 1'b0;
		n.status_valid = 1'b0;
		n.jtag_fail = 1'b0;
		n.restart = 1'b0;
		n.prog_done = 1'b0;

		// Fabric owns the mailbox only while no service runs
		if (mbox_wr_en && !s.busy)
			n.mbox[mbox_addr] = mbox_wdata;
		n.mbox_rdata = s.mbox[mbox_addr];

		// Bit engine: clock idles high, data changes on the falling edge and
		// is taken on the rising edge; the rate is fixed by the divider constant
		if (s.xfer)
		begin
			if (s.div == `SCK_DIV_LAST)
			begin
				n.div = 2'h0;
				if (s.sck)
				begin
					n.sck = 1'b0;
					n.sdo = s.tx[7];
					n.tx = {s.tx[6:0], 1'b0};
				end
				else
				begin
					n.sck = 1'b1;
					n.rx = {s.rx[6:0], spi_sdi};
					n.bit_cnt = s.bit_cnt + 3'h1;
					if (s.bit_cnt == 3'h7)
						n.xfer = 1'b0;
				end
			end
			else
				n.div = s.div + 2'h1;
		end
		if (byte_done && s.state == ST_DATA)
			n.have_rx = 1'b1;

		unique case (s.state)
			ST_BOOT:
			begin
				// Straps are taken once, on the first edge after reset release
				n.en_strap = port_enable_strap;
				n.role_strap = port_role_strap;
				n.state = ST_IDLE;
				n.desc_ready = 1'b1;
				n.busy = 1'b0;
				n.fabric_grant = boot_ok;
				if (boot_ok)
				begin
					if (device_blank)
						n = begin_job(n, JOB_PROGRAM, `UPDATE_IMAGE_ADDR);
					else if (auto_update_enable && version_differs)
						n = begin_job(n, JOB_UPDATE, `UPDATE_IMAGE_ADDR);
					else if (recovery_pending && !secure_nonvolatile_memory_interrupted && !image_authenticated)
						n = begin_job(n, JOB_PROGRAM, `UPDATE_IMAGE_ADDR);
				end
				n.spi_oe_n = n.ss_n | ~port_enable_strap;
			end

			ST_IDLE:
			begin
				n.fabric_grant = allowed;
				if (desc_valid && s.desc_ready)
				begin
					n.desc_ready = 1'b0;
					n.busy = 1'b1;
					n.fabric_grant = 1'b0;
					unique case (cmd)
						`CMD_BITSTREAM_AUTH:
						begin
							if (!allowed)
								n = report(n, `ERR_NOT_MASTER);
							else
							begin
								n.mbox_ptr = offset;
								n.jtag_fail = jtag_load_active;
								n.block_ports = 1'b1;
								n.state = ST_FETCH;
							end
						end
						`CMD_IMAGE_AUTH:
						begin
							if (!allowed)
								n = report(n, `ERR_NOT_MASTER);
							else
								n = begin_job(n, JOB_AUTH,
									`DIR_BASE_ADDR + ({24'h000000, index} << `DIR_STRIDE_SHIFT));
						end
						`CMD_AUTO_UPDATE:
						begin
							// Not master: no error, the request simply does nothing
							if (!allowed)
								n = report(n, `STATUS_OK);
							else
								n = begin_job(n, JOB_UPDATE, `UPDATE_IMAGE_ADDR);
						end
						`CMD_IN_APPLICATION:
						begin
							if (!allowed)
								n = report(n, `ERR_NOT_MASTER);
							else
								n = begin_job(n, JOB_IN_APPLICATION, `IN_APPLICATION_ADDR);
						end
						default:
							n = report(n, `ERR_UNKNOWN_CMD);
					endcase
				end
			end

			ST_FETCH:
			begin
				// Upper address byte drops out: only the low address bytes are sent
				n = begin_job(n, JOB_AUTH, s.mbox[s.mbox_ptr]);
			end

			ST_CMD:
			begin
				if (!s.xfer)
				begin
					if (s.hdr == 3'h0)
					begin
						n = start_byte(n, `FLASH_READ_OP);
						n.hdr = s.hdr + 3'h1;
					end
					else if (s.hdr <= `FLASH_ADDR_BYTES)
					begin
						n = start_byte(n, addr_byte(s.addr, s.hdr));
						n.hdr = s.hdr + 3'h1;
					end
					else
						n.state = ST_DATA;
				end
			end

			ST_DATA:
			begin
				if (!s.xfer)
				begin
					if (s.have_rx)
					begin
						n.have_rx = 1'b0;
						n.count = s.count - 16'h0001;
						if (s.job == JOB_AUTH)
							n.chk = s.chk ^ s.rx;
						else
						begin
							n.push = 1'b1;
							n.push_data = s.rx;
						end
						if (s.count == 16'h0001)
							n.state = ST_FINISH;
					end
					// Program data waits for buffer room; the clock simply
					// parks high, which mode 3 tolerates between bytes
					// A push still in flight is not yet seen in the buffer's ready
					else if (s.job == JOB_AUTH || (buf_ready && !s.push))
						n = start_byte(n, `FLASH_DUMMY_TX);
				end
			end

			ST_FINISH:
			begin
				n.ss_n = 1'b1;
				n.spi_oe_n = 1'b1;
				// Program bytes still buffered keep the job, and the port lock, alive
				if (s.job == JOB_AUTH || (!s.push && !prog_valid))
				begin
					n.block_ports = 1'b0;
					unique case (s.job)
						JOB_AUTH:
						begin
							n.auth_passed = s.chk == 8'h00;
							n = report(n, s.chk == 8'h00 ? `STATUS_OK : `ERR_AUTH_FAIL);
						end
						JOB_IN_APPLICATION:
						begin
							n.prog_done = 1'b1;
							n = report(n, `STATUS_OK);
						end
						default:
						begin
							// Update and auto programming restart the device, so no status
							n.prog_done = 1'b1;
							n.restart = 1'b1;
							n.auth_passed = 1'b0;
							n.busy = 1'b0;
							n.desc_ready = 1'b1;
							n.fabric_grant = allowed;
							n.state = ST_IDLE;
						end
					endcase
				end
			end

			ST_REPORT:
			begin
				n.status_valid = 1'b1;
				n.busy = 1'b0;
				n.block_ports = 1'b0;
				n.desc_ready = 1'b1;
				n.fabric_grant = allowed;
				n.state = ST_IDLE;
			end

			default:
				n.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.state <= ST_BOOT;
			s.sck <= `SCK_IDLE_LEVEL;
			s.ss_n <= 1'b1;
			s.spi_oe_n <= 1'b1;
			s.busy <= 1'b1;
		end
		else
			s <= n;
	end

	////////////////////////////////////////////////////////////////////////////////

	// A stall downstream parks the flash read, so no byte is dropped
	two_entry_buffer u_prog_buffer (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.in_valid  (s.push),
		.in_data   (s.push_data),
		.in_ready  (buf_ready),
		.out_valid (prog_valid),
		.out_data  (prog_data),
		.out_ready (prog_ready)
	);

	assign desc_ready = s.desc_ready;
	assign busy = s.busy;
	assign status_valid = s.status_valid;
	assign status_code = s.status_code;
	assign mbox_rdata = s.mbox_rdata;
	assign spi_sck_o = s.sck;
	assign spi_sck_oe_n = s.spi_oe_n;
	assign spi_ss_n_o = s.ss_n;
	assign spi_ss_oe_n = s.spi_oe_n;
	assign spi_sdo = s.sdo;
	assign spi_sdo_oe_n = s.spi_oe_n;
	assign fabric_spi_grant = s.fabric_grant;
	assign port_block = s.block_ports;
	assign jtag_fail = s.jtag_fail;
	assign auth_passed = s.auth_passed;
	assign restart_request = s.restart;
	assign prog_done = s.prog_done;

endmodule

/* File: tb/self_prog_asserts.sv */
`timescale 1ns/1ps

module self_prog_asserts (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        port_enable_strap,
	input wire logic        port_role_strap,
	input wire logic        suspend_mode,
	input wire logic        jtag_load_active,
	input wire logic        desc_valid,
	input wire logic [15:0] desc,
	input wire logic        desc_ready,
	input wire logic        busy,
	input wire logic        status_valid,
	input wire logic [7:0]  status_code,
	input wire logic        spi_sck_o,
	input wire logic        spi_ss_n_o,
	input wire logic        spi_sdo_oe_n,
	input wire logic        fabric_spi_grant,
	input wire logic        port_block,
	input wire logic        jtag_fail,
	input wire logic        prog_valid,
	input wire logic [7:0]  prog_data,
	input wire logic        prog_ready
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	AST_IDLE_HIGH: assert property (spi_ss_n_o |-> spi_sck_o)
		else $error("serial clock not idle high");
	AST_HALF_PERIOD: assert property ($fell(spi_sck_o) |=> spi_sck_o)
		else $error("serial clock low longer than one cycle");
	AST_PORT_OFF: assert property (!port_enable_strap |-> spi_sdo_oe_n && spi_ss_n_o)
		else $error("flash port driven while disabled");
	AST_NOT_MASTER: assert property (!(port_enable_strap && port_role_strap) |-> spi_ss_n_o)
		else $error("flash selected without master straps");
	AST_UNKNOWN: assert property (desc_valid && desc_ready && port_enable_strap && port_role_strap
		&& !suspend_mode && !(desc[6:0] inside {7'h22, 7'h23, 7'h42, 7'h46})
		|=> ##1 status_valid && status_code == 8'h02)
		else $error("unknown command not reported");
	AST_TAKE: assert property (desc_valid && desc_ready |=> !desc_ready)
		else $error("descriptor accepted while one is running");
	AST_BUSY: assert property (!desc_ready |-> busy)
		else $error("busy low while not ready");
	AST_STATUS_PULSE: assert property (status_valid |=> !status_valid)
		else $error("status strobe longer than one cycle");
	AST_JTAG_LOSES: assert property (desc_valid && desc_ready && desc[6:0] == 7'h23 && jtag_load_active
		&& port_enable_strap && port_role_strap && !suspend_mode |-> ##[1:2] jtag_fail)
		else $error("jtag load not failed");
	AST_SUSPEND: assert property (suspend_mode && desc_valid && desc_ready |=> spi_ss_n_o [*8])
		else $error("flash selected in suspend mode");
	AST_NO_GRANT: assert property (!spi_ss_n_o |-> !fabric_spi_grant)
		else $error("fabric granted the port during a read");
	AST_LOCKED: assert property (prog_valid |-> port_block)
		else $error("ports open during programming");
	AST_STREAM_HOLD: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_data))
		else $error("program byte dropped or changed");
endmodule

bind self_program_services self_prog_asserts u_chk (
	.sys_clk(sys_clk), .resetn(resetn), .port_enable_strap(port_enable_strap), .port_role_strap(port_role_strap),
	.suspend_mode(suspend_mode), .jtag_load_active(jtag_load_active), .desc_valid(desc_valid), .desc(desc),
	.desc_ready(desc_ready), .busy(busy), .status_valid(status_valid), .status_code(status_code),
	.spi_sck_o(spi_sck_o), .spi_ss_n_o(spi_ss_n_o), .spi_sdo_oe_n(spi_sdo_oe_n), .fabric_spi_grant(fabric_spi_grant),
	.port_block(port_block), .jtag_fail(jtag_fail), .prog_valid(prog_valid), .prog_data(prog_data),
	.prog_ready(prog_ready));

/* File: tb/flash_model.sv */
`timescale 1ns/1ps

module flash_model (
	input  wire logic  sck,
	input  wire logic  sel_n,
	input  wire logic  mosi,
	input  wire logic  corrupt,
	output logic       miso,
	output logic [7:0] cmd,
	output logic [31:0] addr,
	output logic [7:0] txns
);
	int          n;
	logic [31:0] hdr;
	logic [7:0]  cur;

	initial
	begin
		miso = 1'b1;
		txns = 8'h00;
		n = 0;
	end

	always @(negedge sel_n)
	begin
		n = 0;
		txns = txns + 8'h01;
	end

	// Mode 3: opcode and address sampled on the rise, MSB first
	always @(posedge sck)
	begin
		if (!sel_n)
		begin
			if (n < 32)
				hdr = {hdr[30:0], mosi};
			if (n == 31)
			begin
				cmd = hdr[31:24];
				addr = {8'h00, hdr[23:0]};
			end
			n = n + 1;
		end
	end

	// Data is the low address byte, so a clean image XORs to zero; pull-up when released
	always @(negedge sck or posedge sel_n)
	begin
		if (sel_n || n < 32)
			miso = 1'b1;
		else
		begin
			cur = 8'(addr + 32'((n - 32) / 8));
			if (corrupt && n < 40)
				cur = ~cur;
			miso = cur[7 - ((n - 32) % 8)];
		end
	end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "self_prog_params.svh"

module testbench;
	logic        sys_clk = 1'b0, resetn = 1'b0, en_s = 1'b1, role_s = 1'b1, susp = 1'b0, aue = 1'b0;
	logic        vdiff = 1'b0, rpend = 1'b0, sint = 1'b0, jtag = 1'b0, dv = 1'b0, wr = 1'b0, prdy = 1'b0;
	logic        corrupt = 1'b0, stall = 1'b1, blank = 1'b0, iauth = 1'b0;
	logic [15:0] desc = 16'h0000;
	logic [8:0]  maddr = 9'h000;
	logic [31:0] mwd = 32'h00000000;
	logic        drdy, busy, sv, sck, sck_oe_n, ss_n, ss_oe_n, sdo, sdo_oe_n, sdi, grant, pblk, jfail, apass;
	logic        rreq, pdone, pv;
	logic [7:0]  sc, pd, fcmd, ftx, n_tx;
	logic [31:0] mrd, faddr;
	logic [7:0]  sq[$];
	logic [7:0]  pq[$];
	int          bad_count = 0, checked = 0, jcnt = 0, seed = 95410;

	wire sck_w = sck_oe_n ? 1'b1 : sck;
	wire sel_w_n = ss_oe_n ? 1'b1 : ss_n;
	wire sdo_w = sdo_oe_n ? 1'b1 : sdo;

	self_program_services u_dut (
		.sys_clk(sys_clk), .resetn(resetn), .port_enable_strap(en_s), .port_role_strap(role_s),
		.suspend_mode(susp), .auto_update_enable(aue), .device_blank(blank), .version_differs(vdiff),
		.recovery_pending(rpend), .secure_nonvolatile_memory_interrupted(sint),
		.image_authenticated(iauth), .jtag_load_active(jtag),
		.desc_valid(dv), .desc(desc), .desc_ready(drdy), .busy(busy), .status_valid(sv), .status_code(sc),
		.mbox_wr_en(wr), .mbox_addr(maddr), .mbox_wdata(mwd), .mbox_rdata(mrd), .spi_sck_o(sck),
		.spi_sck_oe_n(sck_oe_n), .spi_ss_n_o(ss_n), .spi_ss_oe_n(ss_oe_n), .spi_sdo(sdo), .spi_sdo_oe_n(sdo_oe_n),
		.spi_sdi(sdi), .fabric_spi_grant(grant), .port_block(pblk), .jtag_fail(jfail), .auth_passed(apass),
		.restart_request(rreq), .prog_done(pdone), .prog_valid(pv), .prog_data(pd), .prog_ready(prdy));

	flash_model u_flash (.sck(sck_w), .sel_n(sel_w_n), .mosi(sdo_w), .corrupt(corrupt), .miso(sdi),
		.cmd(fcmd), .addr(faddr), .txns(ftx));

	initial
	begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic end_of_test;
		$display("counts checked=%0d bad=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic sel(input int w);
		return (w == 0) ? drdy : (w == 1) ? rreq : pdone;
	endfunction

	task automatic wait_hi(input int w, input int lim);
		int i;
		i = 0;
		while (sel(w) !== 1'b1 && i < lim)
		begin
			@(negedge sys_clk);
			i++;
		end
		if (i >= lim)
		begin
			chk(32'h0, 32'h1);
			end_of_test;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic boot(input logic e, input logic r, input logic a, input logic v, input logic p, input logic s);
		@(posedge sys_clk);
		resetn <= 1'b0;
		{en_s, role_s, aue, vdiff, rpend, sint} <= {e, r, a, v, p, s};
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
	endtask

	// Held from one rising edge until the edge that takes it
	task automatic send(input logic [15:0] d, input logic [7:0] e, input bit keep);
		wait_hi(0, 40000);
		@(posedge sys_clk);
		if (keep)
			sq.push_back(e);
		dv <= 1'b1;
		desc <= d;
		@(posedge sys_clk);
		dv <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic expect_image;
		for (int i = 0; i < `IMAGE_BYTES; i++)
			pq.push_back(8'(i));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk)
	begin
		if (sv === 1'b1 && sq.size() > 0)
			chk(sc, sq.pop_front());
		if (pv === 1'b1 && prdy === 1'b1)
			chk(pd, (pq.size() > 0) ? pq.pop_front() : 8'hxx);
		if (jfail === 1'b1)
			jcnt++;
		prdy <= ~stall & 1'($random(seed));
	end

	initial
	begin
		boot(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		tick(3);
		chk(drdy, 1);
		chk(ss_n, 1);
		send(16'h007f, 8'h02, 1);
		wait_hi(0, 100);
		@(posedge sys_clk);
		wr <= 1'b1;
		maddr <= 9'h005;
		mwd <= 32'h00004000;
		@(posedge sys_clk);
		wr <= 1'b0;
		tick(2);
		chk(mrd, 32'h00004000);
		$display("done: boot gating, unknown code, mailbox");
		jtag <= 1'b1;
		send({9'd5, 7'h23}, 8'h00, 1);
		jtag <= 1'b0;
		wait_hi(0, 40000);
		chk(jcnt, 1);
		chk(fcmd, 8'h03);
		chk(faddr, 32'h00004000);
		chk(apass, 1);
		$display("done: bitstream authentication");
		corrupt <= 1'b1;
		send({1'b0, 8'd2, 7'h22}, 8'h03, 1);
		wait_hi(0, 40000);
		corrupt <= 1'b0;
		chk(faddr, 32'h00120000);
		chk(apass, 0);
		$display("done: image authentication failure");
		susp <= 1'b1;
		n_tx = ftx;
		send(16'h0042, 8'h01, 1);
		wait_hi(0, 200);
		chk(ftx, n_tx);
		susp <= 1'b0;
		$display("done: suspend");
		expect_image();
		send(16'h0042, 8'h00, 1);
		// Consumer held off long enough to fill the buffer and stall the flash read
		tick(300);
		chk(pv, 1);
		chk(pd, 8'h00);
		stall <= 1'b0;
		wait_hi(2, 60000);
		tick(20);
		chk(pq.size(), 0);
		chk(faddr, 32'h00002000);
		$display("done: in-application programming");
		boot(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		send(16'h0042, 8'h01, 1);
		send(16'h0046, 8'h00, 1);
		wait_hi(0, 100);
		boot(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		send(16'h0042, 8'h01, 1);
		wait_hi(0, 100);
		tick(2);
		chk(sq.size(), 0);
		$display("done: strap combinations");
		expect_image();
		boot(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		wait_hi(1, 60000);
		chk(faddr, 32'h00001000);
		chk(pq.size(), 0);
		$display("done: boot update");
		n_tx = ftx;
		iauth <= 1'b1;
		boot(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		tick(40);
		chk(ftx, n_tx);
		chk(drdy, 1);
		iauth <= 1'b0;
		expect_image();
		boot(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		wait_hi(1, 60000);
		chk(ftx, n_tx + 8'h01);
		chk(pq.size(), 0);
		blank <= 1'b1;
		expect_image();
		boot(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_hi(1, 60000);
		blank <= 1'b0;
		chk(faddr, 32'h00001000);
		chk(pq.size(), 0);
		$display("done: recovery and blank programming");
		end_of_test;
	end
endmodule
